// File: hdl/acp_defines.svh
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH

// Clock and timing figures
`define ACP_CLK_PERIOD_NS 5
`define ACP_GLITCH_NS     50
`define ACP_GLITCH_CYC    (`ACP_GLITCH_NS / `ACP_CLK_PERIOD_NS)
`define ACP_ABORT_NS      1000
`define ACP_ABORT_CYC     (`ACP_ABORT_NS / `ACP_CLK_PERIOD_NS)

// Bus activity is remembered this many cycles after the last line edge
`define ACP_ACT_HOLD      4'h4

// Successive-approximation trials per conversion
`define ACP_NUM_TRIALS    12

// Configuration register layout
`define ACP_CFG_RESET     16'h0000
`define ACP_CFG_WMASK     16'h7FFF
`define ACP_B_NDS         14
`define ACP_B_NDT         13
`define ACP_B_AUTO        12
`define ACP_B_PSD1        11
`define ACP_B_PSD0        10
`define ACP_B_DIF1        9
`define ACP_B_DIF0        8
`define ACP_B_RNG_HI      7
`define ACP_B_RNG_LO      4
`define ACP_B_FILT        3
`define ACP_B_PIN_HI      2
`define ACP_B_PIN_LO      1
`define ACP_B_POL         0

// Pin function codes in D2:D1
`define ACP_PIN_OFF       2'h0
`define ACP_PIN_BUSY      2'h1
`define ACP_PIN_ALERT     2'h2
`define ACP_PIN_CLEAR     2'h3

`endif

// File: hdl/acp_pkg.sv
package acp_pkg;

	// Conversion sequencer states
	typedef enum logic [1:0] {
		ACP_IDLE,
		ACP_SAMPLE,
		ACP_TRIAL
	} acp_state_t;

endpackage : acp_pkg

// File: hdl/acp_glitch_filter.sv
`timescale 1ns/1ps
`include "acp_defines.svh"

module acp_glitch_filter (
	input  wire logic clock,    // System clock
	input  wire logic rstn,     // Async reset, active low
	input  wire logic line_in,  // Raw bus line, asynchronous
	input  wire logic bypass,   // High removes the filtering
	output logic      line_out  // Synchronised, filtered line
);

	logic       sync1_reg;
	logic       sync2_reg;
	logic       filt_reg;
	logic       filt_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;

	// Two-stage synchroniser; idle bus level is high
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= line_in;
			sync2_reg <= sync1_reg;
		end
	end

	// A new level must hold for the full glitch window before it passes
	always_comb begin
		filt_next = filt_reg;
		cnt_next  = 4'h0;
		if (bypass) begin
			filt_next = sync2_reg;
		end else if (sync2_reg != filt_reg) begin
			if (cnt_reg == 4'(`ACP_GLITCH_CYC - 1)) begin
				filt_next = sync2_reg; // R06
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			filt_reg <= 1'b1;
			cnt_reg  <= 4'h0;
		end else begin
			filt_reg <= filt_next;
			cnt_reg  <= cnt_next;
		end
	end

	assign line_out = filt_reg;

endmodule : acp_glitch_filter

// File: hdl/acp_config_ctrl.sv
`timescale 1ns/1ps
`include "acp_defines.svh"

// What this block does
// R01: Delay sampling, delay trials, filters enabled at power-up
// R02: Postpone sampling while the bus is active
// R03: Hold bit trials while the bus is active
// R04: Disabled delay gives a fixed sampling instant
// R05: Postponement beyond one microsecond aborts the conversion
// R06: Filter rejects bus pulses under 50 ns
// R07: Host should keep bus idle during conversions
// R08: Code 00 leaves the event pin silent
// R09: Code 01 makes the pin a busy output
// R10: Code 10 makes the pin an alert output
// R11: Code 11 clears pin, flag and alert status
// R12: After clear the pin field reads 10
// R13: D0 sets alert polarity, D12 enables autocycle
// R14: D8-D11 enable differential and pseudo-differential pairs
// R15: Sixteen-bit register, D14-D0 read/write, D15 always reads zero, zero at power-up

module acp_config_ctrl (
	input  wire logic        clock,         // System clock, 200 MHz
	input  wire logic        rstn,          // Async reset, active low
	input  wire logic        scl_pin,       // Bus clock line, asynchronous
	input  wire logic        sda_pin,       // Bus data line, asynchronous
	input  wire logic        cfg_wr_en,     // One-cycle register write strobe
	input  wire logic [15:0] cfg_wr_data,   // Register write data
	output logic      [15:0] cfg_rd_data,   // Register read-back
	input  wire logic        conv_start,    // One-cycle conversion request
	input  wire logic        limit_alert,   // One-cycle limit violation
	output logic             pin_out,       // Event/busy pin level
	output logic             pin_oe,        // Event/busy pin drive enable
	output logic             sample_strobe, // One-cycle sampling instant
	output logic             trial_strobe,  // One-cycle bit trial
	output logic             conv_abort,    // One-cycle conversion abort
	output logic             conv_done,     // One-cycle conversion end
	output logic             clear_alerts,  // One-cycle flag and status clear
	output logic             autocycle_en,  // Autocycle mode enable
	output logic      [1:0]  diff_pair,     // Differential pair enables
	output logic      [1:0]  pseudo_pair,   // Pseudo-differential enables
	output logic      [3:0]  range_2x       // Double input range enables
);

	logic [1:0] line_filt;
	logic [1:0] line_prev_reg;
	logic [3:0] act_reg;
	logic [3:0] act_next;
	logic       bus_act;

	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic        clear_next;
	logic        pend_reg;
	logic        pend_next;

	acp_pkg::acp_state_t st_reg;
	acp_pkg::acp_state_t st_next;
	logic [7:0] wait_reg;
	logic [7:0] wait_next;
	logic [3:0] bits_reg;
	logic [3:0] bits_next;
	logic       sample_next;
	logic       trial_next;
	logic       abort_next;
	logic       done_next;
	logic       pin_out_next;
	logic       pin_oe_next;

	// One filter per bus line; D3 high bypasses them
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			acp_glitch_filter u_filt (
				.clock    (clock),
				.rstn     (rstn),
				.line_in  ((gi == 0) ? scl_pin : sda_pin),
				.bypass   (cfg_reg[`ACP_B_FILT]), // R06
				.line_out (line_filt[gi])
			);
		end
	endgenerate

	// Bus activity: any edge on either line, held a few cycles so that
	// closely spaced edges count as one busy stretch
	always_comb begin
		act_next = (act_reg != 4'h0) ? act_reg - 4'h1 : 4'h0;
		if (line_filt != line_prev_reg) begin
			act_next = `ACP_ACT_HOLD;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			line_prev_reg <= 2'h3;
			act_reg       <= 4'h0;
		end else begin
			line_prev_reg <= line_filt;
			act_reg       <= act_next;
		end
	end

	assign bus_act = (act_reg != 4'h0);

	// Register writes; a clear code is stored as alert mode
	always_comb begin
		cfg_next   = cfg_reg;
		clear_next = 1'b0;
		pend_next  = pend_reg;
		if (cfg_wr_en) begin
			cfg_next = cfg_wr_data & `ACP_CFG_WMASK; // R15
			if (cfg_wr_data[`ACP_B_PIN_HI:`ACP_B_PIN_LO] == `ACP_PIN_CLEAR) begin
				cfg_next[`ACP_B_PIN_HI:`ACP_B_PIN_LO] = `ACP_PIN_ALERT; // R12
				clear_next = 1'b1; // R11
				pend_next  = 1'b0; // R11
			end
		end
		// A violation in the clear cycle survives the clear
		if (limit_alert) begin
			pend_next = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg_reg      <= `ACP_CFG_RESET; // R01 R15
			clear_alerts <= 1'b0;
			pend_reg     <= 1'b0;
		end else begin
			cfg_reg      <= cfg_next;
			clear_alerts <= clear_next;
			pend_reg     <= pend_next;
		end
	end

	// Conversion sequencer: sampling instant, then the bit trials
	always_comb begin
		st_next     = st_reg;
		wait_next   = wait_reg;
		bits_next   = bits_reg;
		sample_next = 1'b0;
		trial_next  = 1'b0;
		abort_next  = 1'b0;
		done_next   = 1'b0;
		case (st_reg)
			acp_pkg::ACP_IDLE: begin
				if (conv_start) begin
					st_next   = acp_pkg::ACP_SAMPLE;
					wait_next = 8'h00;
				end
			end
			acp_pkg::ACP_SAMPLE: begin
				if (!cfg_reg[`ACP_B_NDS] && bus_act) begin
					if (wait_reg == 8'(`ACP_ABORT_CYC)) begin
						abort_next = 1'b1; // R05
						st_next    = acp_pkg::ACP_IDLE;
					end else begin
						wait_next = wait_reg + 8'h01; // R02
					end
				end else begin
					sample_next = 1'b1; // R04
					st_next     = acp_pkg::ACP_TRIAL;
					bits_next   = 4'(`ACP_NUM_TRIALS - 1);
				end
			end
			acp_pkg::ACP_TRIAL: begin
				// Held trials stretch the conversion time
				if (cfg_reg[`ACP_B_NDT] || !bus_act) begin // R03
					trial_next = 1'b1;
					if (bits_reg == 4'h0) begin
						done_next = 1'b1;
						st_next   = acp_pkg::ACP_IDLE;
					end else begin
						bits_next = bits_reg - 4'h1;
					end
				end
			end
			default: begin
				st_next = acp_pkg::ACP_IDLE;
			end
		endcase
	end

	// Event pin: silent, busy, or alert with selectable polarity
	always_comb begin
		pin_oe_next  = 1'b0;
		pin_out_next = 1'b0;
		case (cfg_reg[`ACP_B_PIN_HI:`ACP_B_PIN_LO])
			`ACP_PIN_BUSY: begin
				pin_oe_next  = 1'b1; // R09
				pin_out_next = (st_reg != acp_pkg::ACP_IDLE);
			end
			`ACP_PIN_ALERT: begin
				pin_oe_next  = 1'b1; // R10
				pin_out_next = ~(pend_reg ^ cfg_reg[`ACP_B_POL]); // R13
			end
			default: begin
				pin_oe_next = 1'b0; // R08
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg        <= acp_pkg::ACP_IDLE;
			wait_reg      <= 8'h00;
			bits_reg      <= 4'h0;
			sample_strobe <= 1'b0;
			trial_strobe  <= 1'b0;
			conv_abort    <= 1'b0;
			conv_done     <= 1'b0;
			pin_out       <= 1'b0;
			pin_oe        <= 1'b0;
		end else begin
			st_reg        <= st_next;
			wait_reg      <= wait_next;
			bits_reg      <= bits_next;
			sample_strobe <= sample_next;
			trial_strobe  <= trial_next;
			conv_abort    <= abort_next;
			conv_done     <= done_next;
			pin_out       <= pin_out_next;
			pin_oe        <= pin_oe_next;
		end
	end

	// Mode outputs and read-back, all registered copies of the register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg_rd_data  <= `ACP_CFG_RESET;
			autocycle_en <= 1'b0;
			diff_pair    <= 2'h0;
			pseudo_pair  <= 2'h0;
			range_2x     <= 4'h0;
		end else begin
			cfg_rd_data  <= cfg_reg;
			autocycle_en <= cfg_reg[`ACP_B_AUTO]; // R13
			diff_pair    <= cfg_reg[`ACP_B_DIF1:`ACP_B_DIF0]; // R14
			pseudo_pair  <= cfg_reg[`ACP_B_PSD1:`ACP_B_PSD0]; // R14
			range_2x     <= cfg_reg[`ACP_B_RNG_HI:`ACP_B_RNG_LO];
		end
	end

	cfg_reset_a: assert property (@(posedge clock) $rose(rstn) |-> cfg_reg == 16'h0000) // R01
		else $error("config not zero after reset");

	samp_hold_a: assert property (@(posedge clock) disable iff (!rstn) // R02
		(st_reg == acp_pkg::ACP_SAMPLE && !cfg_reg[`ACP_B_NDS] && bus_act)
		|=> !sample_strobe)
		else $error("sample taken during bus activity");

	trial_hold_a: assert property (@(posedge clock) disable iff (!rstn) // R03
		(st_reg == acp_pkg::ACP_TRIAL && !cfg_reg[`ACP_B_NDT] && bus_act)
		|=> !trial_strobe && st_reg == acp_pkg::ACP_TRIAL)
		else $error("bit trial during bus activity");

	fixed_samp_a: assert property (@(posedge clock) disable iff (!rstn) // R04
		(st_reg == acp_pkg::ACP_SAMPLE && cfg_reg[`ACP_B_NDS])
		|=> sample_strobe && st_reg == acp_pkg::ACP_TRIAL)
		else $error("fixed sample not taken at once");

	abort_time_a: assert property (@(posedge clock) disable iff (!rstn) // R05
		(st_reg == acp_pkg::ACP_SAMPLE && !cfg_reg[`ACP_B_NDS] && bus_act
		 && wait_reg == 8'(`ACP_ABORT_CYC))
		|=> conv_abort && st_reg == acp_pkg::ACP_IDLE)
		else $error("overlong postponement not aborted");

	pin_off_a: assert property (@(posedge clock) disable iff (!rstn) // R08
		(cfg_reg[2:1] == 2'h0) |=> !pin_oe)
		else $error("pin driven while disabled");

	busy_pin_a: assert property (@(posedge clock) disable iff (!rstn) // R09
		(cfg_reg[2:1] == 2'h1)
		|=> pin_oe && pin_out == ($past(st_reg) != acp_pkg::ACP_IDLE))
		else $error("busy pin wrong");

	alert_pin_a: assert property (@(posedge clock) disable iff (!rstn) // R10
		(cfg_reg[2:1] == 2'h2)
		|=> pin_oe && pin_out == ($past(pend_reg) == $past(cfg_reg[0])))
		else $error("alert pin wrong");

	clear_cmd_a: assert property (@(posedge clock) disable iff (!rstn) // R11
		(cfg_wr_en && cfg_wr_data[2:1] == 2'h3 && !limit_alert)
		|=> clear_alerts && !pend_reg ##1 (!clear_alerts || $past(cfg_wr_en)))
		else $error("clear command not applied");

	clear_read_a: assert property (@(posedge clock) disable iff (!rstn) // R12
		(cfg_wr_en && cfg_wr_data[2:1] == 2'h3) |=> ##1 cfg_rd_data[2:1] == 2'h2)
		else $error("clear code did not read back as alert mode");

	// Read-back lags a write by two edges; a write right after it cannot disturb it
	rd_back_a: assert property (@(posedge clock) disable iff (!rstn) // R15
		(cfg_wr_en && cfg_wr_data[`ACP_B_PIN_HI:`ACP_B_PIN_LO] != `ACP_PIN_CLEAR)
		|=> ##1 cfg_rd_data == $past(cfg_wr_data & `ACP_CFG_WMASK, 2))
		else $error("register read-back wrong");

	mode_copy_a: assert property (@(posedge clock) disable iff (!rstn) // R13 R14
		autocycle_en == $past(cfg_reg[`ACP_B_AUTO])
		&& diff_pair == $past(cfg_reg[`ACP_B_DIF1:`ACP_B_DIF0])
		&& pseudo_pair == $past(cfg_reg[`ACP_B_PSD1:`ACP_B_PSD0]))
		else $error("mode outputs do not follow the register");

	done_last_a: assert property (@(posedge clock) disable iff (!rstn) // R03
		conv_done |-> trial_strobe && st_reg == acp_pkg::ACP_IDLE)
		else $error("conversion end without final trial");

endmodule : acp_config_ctrl

// File: testbench/acp_host_model.sv
`timescale 1ns/1ps

// Bus host stand-in: lines rest high as the pull-ups leave them, and the
// data line only moves in bursts that the bench asks for
module acp_host_model (
	input  wire logic       clock,   // System clock
	input  wire logic       go,      // One-cycle burst request
	input  wire logic [7:0] half_w,  // Cycles between edges
	input  wire logic [7:0] n_edges, // Edges per burst, multiple of four
	output logic            scl_pin, // Bus clock line
	output logic            sda_pin  // Bus data line
);
	// Idle bus outside bursts keeps conversions undisturbed; inside a burst
	// the lines take turns on falling clock edges, so both filters are used
	initial begin
		scl_pin = 1'b1;
		sda_pin = 1'b1;
		forever begin
			@(posedge clock);
			if (go) begin
				for (int k = 0; k < n_edges; k++) begin
					repeat (half_w) @(negedge clock);
					if (k % 2 == 1)
						scl_pin = ~scl_pin;
					else
						sda_pin = ~sda_pin;
				end
			end
		end
	end
endmodule : acp_host_model

// File: testbench/adc_config_alert_pin_control_bench.sv
`timescale 1ns/1ps

module adc_config_alert_pin_control_bench;
	logic        clock, rstn, scl_pin, sda_pin, cfg_wr_en, conv_start, limit_alert;
	logic [15:0] cfg_wr_data, cfg_rd_data;
	logic        pin_out, pin_oe, sample_strobe, trial_strobe, conv_abort, conv_done;
	logic        clear_alerts, autocycle_en, go, ab, pb, clr_seen;
	logic [1:0]  diff_pair, pseudo_pair;
	logic [3:0]  range_2x;
	logic [7:0]  half_w, n_edges;
	int          n_errors, checked, ts, nt, te, ts0, te0;

	acp_config_ctrl dut_u (.clock(clock), .rstn(rstn), .scl_pin(scl_pin),
		.sda_pin(sda_pin), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
		.cfg_rd_data(cfg_rd_data), .conv_start(conv_start), .limit_alert(limit_alert),
		.pin_out(pin_out), .pin_oe(pin_oe), .sample_strobe(sample_strobe),
		.trial_strobe(trial_strobe), .conv_abort(conv_abort), .conv_done(conv_done),
		.clear_alerts(clear_alerts), .autocycle_en(autocycle_en),
		.diff_pair(diff_pair), .pseudo_pair(pseudo_pair), .range_2x(range_2x));

	acp_host_model host_u (.clock(clock), .go(go), .half_w(half_w),
		.n_edges(n_edges), .scl_pin(scl_pin), .sda_pin(sda_pin));

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task stop_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// Write strobe, then watch three cycles so the clear pulse is not missed
	task wr(input logic [15:0] d);
		cfg_wr_data = d;
		cfg_wr_en = 1'b1;
		@(negedge clock);
		cfg_wr_en = 1'b0;
		clr_seen = clear_alerts;
		repeat (3) begin
			@(negedge clock);
			clr_seen = clr_seen | clear_alerts;
		end
	endtask : wr

	task alert;
		limit_alert = 1'b1;
		@(negedge clock);
		limit_alert = 1'b0;
		repeat (2) @(negedge clock);
	endtask : alert

	// One conversion: sample time, trial count, end time, abort flag
	task conv;
		ts = 0;
		nt = 0;
		te = 0;
		ab = 1'b0;
		conv_start = 1'b1;
		@(negedge clock);
		conv_start = 1'b0;
		for (int i = 1; i < 1000 && te == 0; i++) begin
			@(negedge clock);
			if (i == 4) pb = pin_out;
			if (sample_strobe === 1'b1) ts = i;
			if (trial_strobe === 1'b1) nt++;
			if (conv_done === 1'b1 || conv_abort === 1'b1) te = i;
			if (conv_abort === 1'b1) ab = 1'b1;
		end
		repeat (3) @(negedge clock);
	endtask : conv

	// Configure, start a burst of bus edges, convert, let the bus go quiet
	task nconv(input logic [15:0] cfg, input logic [7:0] hw, input logic [7:0] ne);
		wr(cfg);
		half_w = hw;
		n_edges = ne;
		go = 1'b1;
		@(negedge clock);
		go = 1'b0;
		repeat (20) @(negedge clock);
		conv;
		repeat (int'(hw) * int'(ne)) @(negedge clock);
	endtask : nconv

	// Generous bound; the sequence needs about 2000 cycles
	initial begin
		#100000;
		n_errors++;
		stop_test;
	end

	initial begin
		n_errors = 0;
		checked = 0;
		rstn = 1'b0;
		{cfg_wr_en, conv_start, limit_alert, go} = 4'h0;
		cfg_wr_data = 16'h0000;
		half_w = 8'h00;
		n_edges = 8'h00;
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		@(negedge clock);
		chk("rd_reset", cfg_rd_data, 16'h0000);
		alert;
		chk("oe_off", {15'h0000, pin_oe}, 16'h0000);
		wr(16'hFFF5);
		chk("rd_all", cfg_rd_data, 16'h7FF5);
		chk("auto", {15'h0000, autocycle_en}, 16'h0001);
		chk("pairs", {12'h000, pseudo_pair, diff_pair}, 16'h000F);
		chk("range", {12'h000, range_2x}, 16'h000F);
		chk("alert_hi", {14'h0000, pin_oe, pin_out}, 16'h0003);
		wr(16'h0006);
		chk("clr_pulse", {15'h0000, clr_seen}, 16'h0001);
		chk("rd_clear", cfg_rd_data, 16'h0004);
		chk("alert_lo_idle", {14'h0000, pin_oe, pin_out}, 16'h0003);
		alert;
		chk("alert_lo", {14'h0000, pin_oe, pin_out}, 16'h0002);
		wr(16'h0002);
		conv;
		ts0 = ts;
		te0 = te;
		chk("trials", 16'(nt), 16'h000C);
		chk("busy_pin", {15'h0000, pb}, 16'h0001);
		chk("busy_idle", {14'h0000, pin_oe, pin_out}, 16'h0002);
		nconv(16'h0002, 8'h03, 8'h40);
		chk("filtered", 16'(ts), 16'(ts0));
		nconv(16'h000A, 8'h03, 8'h40);
		chk("postponed", {15'h0000, ts > ts0 + 50}, 16'h0001);
		chk("no_abort", {15'h0000, ab}, 16'h0000);
		nconv(16'h000A, 8'h03, 8'hA0);
		chk("abort", {15'h0000, ab}, 16'h0001);
		chk("abort_t", {15'h0000, te > ts0 + 190 && te < ts0 + 210}, 16'h0001);
		nconv(16'h400A, 8'h03, 8'h40);
		chk("fixed", 16'(ts), 16'(ts0));
		chk("held", {15'h0000, te > te0}, 16'h0001);
		nconv(16'h600A, 8'h03, 8'h40);
		chk("unheld", 16'(te), 16'(te0));
		// Reset in mid-run must bring the register back to zero
		rstn = 1'b0;
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		@(negedge clock);
		chk("rd_reset2", cfg_rd_data, 16'h0000);
		chk("oe_reset2", {15'h0000, pin_oe}, 16'h0000);
		stop_test;
	end
endmodule : adc_config_alert_pin_control_bench
